/* logic/sbs_pkg.sv */
// Constants, types and helpers shared by the burst memory control block
`default_nettype none
package sbs_pkg;
  localparam int SBS_ADDR_W = 18;
  localparam int SBS_LANES = 4;
  localparam int SBS_LANE_W = 9;
  localparam int SBS_DATA_W = SBS_LANES * SBS_LANE_W;
  localparam int SBS_PAR_BIT = 8;
  localparam logic [1:0] SBS_CNT_RST = 2'h0;
  localparam logic [1:0] SBS_CNT_STEP = 2'h1;
  // Levels a floating mode pin settles to through its internal pull
  localparam logic SBS_DEF_DRIVE_SEL = 1'h1; // RULE_14
  localparam logic SBS_DEF_DESEL_DEPTH = 1'h1; // RULE_14
  localparam logic SBS_DEF_FLOW_N = 1'h1; // RULE_14
  localparam logic SBS_DEF_SLEEP = 1'h0; // RULE_14
  localparam logic SBS_DEF_PARITY_N = 1'h0; // RULE_14

  typedef enum logic [2:0] {
    ST_DESEL = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } sbs_state_t;

  // Low address bits for a preset and a count of advances
  function automatic logic [1:0] sbs_burst_addr(
    input logic [1:0] preset,
    input logic [1:0] count,
    input logic interleave
  );
    logic [1:0] res;
    res = interleave ? (preset ^ count) : (preset + count);
    return res;
  endfunction : sbs_burst_addr
endpackage : sbs_pkg
`default_nettype wire

/* logic/sbs_mem.sv */
// Byte-lane writable storage array with a registered read port
`default_nettype none
module sbs_mem
  import sbs_pkg::*;
#(
  parameter int AW = SBS_ADDR_W,
  parameter int LANES = SBS_LANES,
  parameter int LANE_W = SBS_LANE_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Write port
  input wire logic [LANES-1:0] lane_we,
  input wire logic [AW-1:0] addr,
  input wire logic [LANES*LANE_W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  output logic [LANES*LANE_W-1:0] rd_data_q
);
  logic [LANES*LANE_W-1:0] mem [0:(1<<AW)-1];

  // The array has no reset so contents survive reset and standby
  always_ff @(posedge clk_sys) begin // RULE_20
    for (int i = 0; i < LANES; i++) begin
      if (lane_we[i]) begin
        mem[addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= mem[addr];
    end
  end
endmodule : sbs_mem
`default_nettype wire

/* logic/sbs_ctrl.sv */
// Control side of a synchronous burst static memory with its array
// Notes on behaviour
// RULE_01: Two low address bits are the LSBs and preset the burst counter.
// RULE_02: Four active-low lane selects, each governs one data byte lane.
// RULE_03: With byte-write qualifier low, write only selected lanes.
// RULE_04: Global write low writes every lane, ignoring other write inputs.
// RULE_05: Access accepted only with low select low and high select high.
// RULE_06: Output enable active low; high turns the data drivers off.
// RULE_07: Advance low during a burst steps counter to next address.
// RULE_08: Either address strobe captures a new address and starts a burst.
// RULE_09: Sleep high puts the device into standby; low operates normally.
// RULE_10: Flow-through output when mode low, pipelined output when high.
// RULE_11: Burst order low counts linear, high counts interleaved.
// RULE_12: Deselect depth low is dual cycle, high is single cycle.
// RULE_13: Parity enable low activates the ninth lane bit; high removes it.
// RULE_14: Floating pins: drive, depth, flow select high; sleep, parity low.
// RULE_15: Linear order adds one modulo four from the preset value.
// RULE_16: Interleaved order XORs the preset with a counter 00 to 11.
// RULE_17: After four addresses the fifth advance returns to the preset; the code returns there on the fourth advance.
// RULE_18: Inputs sample on rising edge; output enable and sleep are async.
// RULE_19: Single deselect turns outputs off at once; dual one cycle later.
// RULE_20: Memory contents are kept through sleep and stopped clock.
// RULE_21: During a burst only the two low address bits change.
`default_nettype none
module sbs_ctrl
  import sbs_pkg::*;
#(
  parameter int ADDR_W = SBS_ADDR_W,
  parameter int LANES = SBS_LANES,
  parameter int LANE_W = SBS_LANE_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Address
  input wire logic [ADDR_W-3:0] upper_address,
  input wire logic [1:0] low_address_bits,
  // Strobes, selects and advance
  input wire logic processor_address_strobe_n,
  input wire logic controller_address_strobe_n,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic counter_advance_n,
  // Write controls
  input wire logic [LANES-1:0] lane_write_selects_n,
  input wire logic byte_write_qualifier_n,
  input wire logic global_write_n,
  // Asynchronous controls
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // Static mode inputs
  input wire logic flow_through_select_n,
  input wire logic linear_order_select_n,
  input wire logic deselect_depth_select,
  input wire logic parity_lane_enable_n,
  // Data pins, split into input, output and enable
  input wire logic [LANES*LANE_W-1:0] dq_in,
  output logic [LANES*LANE_W-1:0] dq_out,
  output logic [LANES*LANE_W-1:0] dq_oe,
  // Status
  output logic standby
);
  localparam int DW = LANES * LANE_W;

  sbs_state_t state_q, state_d;
  logic [ADDR_W-3:0] hi_q;
  logic [1:0] preset_q, preset_d;
  logic [1:0] cnt_q, cnt_d;
  logic s1_q, s2_q, s2_d;
  logic [DW-1:0] pipe_q;
  logic [DW-1:0] mem_rd_q;

  // Command decode
  wire cs_active = ~chip_select_low_n & chip_select_high; // RULE_05
  wire awake = ~sleep_request; // RULE_09
  // The processor strobe is ignored while the low select is high
  wire proc_go = ~processor_address_strobe_n & ~chip_select_low_n;
  wire strobe_seen = awake & (proc_go | ~controller_address_strobe_n);
  wire begin_burst = strobe_seen & cs_active; // RULE_08
  wire deselect_cmd = (strobe_seen & ~cs_active) | sleep_request;
  wire cont = awake & ~strobe_seen & (state_q != ST_DESEL);
  wire advance = cont & ~counter_advance_n; // RULE_07
  wire access = begin_burst | cont;
  wire write_req = ~global_write_n | ~byte_write_qualifier_n;
  // A processor-strobed start is always a read cycle
  wire is_write = access & write_req & ~(begin_burst & proc_go);
  wire is_read = access & ~is_write;

  // Mode decode
  wire interleave = linear_order_select_n; // RULE_11
  wire flow_through = ~flow_through_select_n; // RULE_10
  wire single_desel = deselect_depth_select; // RULE_12
  wire parity_on = ~parity_lane_enable_n; // RULE_13

  // Burst address generation
  always_comb begin
    preset_d = preset_q;
    cnt_d = cnt_q;
    if (begin_burst) begin
      preset_d = low_address_bits; // RULE_01
      cnt_d = SBS_CNT_RST;
    end else if (advance) begin
      cnt_d = cnt_q + SBS_CNT_STEP; // RULE_17
    end
  end

  // Counter wraps modulo four so the fourth advance lands on the preset
  wire [1:0] cur_low = begin_burst ? low_address_bits :
    sbs_burst_addr(preset_q, cnt_d, interleave); // RULE_15 RULE_16
  wire [ADDR_W-3:0] cur_hi = begin_burst ? upper_address : hi_q; // RULE_21
  wire [ADDR_W-1:0] cur_addr = {cur_hi, cur_low};

  // Lane write enables
  wire [LANES-1:0] lane_sel = ~lane_write_selects_n; // RULE_02
  wire [LANES-1:0] lane_we = ~is_write ? '0 :
    ~global_write_n ? '1 : // RULE_04
    ~byte_write_qualifier_n ? lane_sel : '0; // RULE_03

  // Ninth bit of each lane, used for both write data and drivers
  wire [DW-1:0] par_mask;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign par_mask[g*LANE_W +: LANE_W] =
        {parity_on, {(LANE_W-1){1'b1}}};
    end
  endgenerate
  wire [DW-1:0] wr_data = dq_in & par_mask; // RULE_13

  sbs_mem #(
    .AW(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .lane_we(lane_we),
    .addr(cur_addr),
    .wr_data(wr_data),
    .rd_en(is_read),
    .rd_data_q(mem_rd_q)
  );

  // State of the access in progress
  always_comb begin
    case (state_q)
      ST_DESEL, ST_READ, ST_WRITE: begin
        if (deselect_cmd) begin
          state_d = ST_DESEL;
        end else if (access) begin
          state_d = is_write ? ST_WRITE : ST_READ;
        end else begin
          state_d = state_q;
        end
      end
      default: state_d = ST_DESEL;
    endcase
  end

  // Single deselect cuts the second stage short; writes free the bus too
  assign s2_d = s1_q & ~(deselect_cmd & single_desel) & ~is_write; // RULE_19

  // All synchronous controls are taken on the rising edge
  always_ff @(posedge clk_sys or posedge rst) begin // RULE_18
    if (rst) begin
      state_q <= ST_DESEL;
      hi_q <= '0;
      preset_q <= SBS_CNT_RST;
      cnt_q <= SBS_CNT_RST;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (begin_burst) begin
        hi_q <= upper_address;
      end
      preset_q <= preset_d;
      cnt_q <= cnt_d;
      s1_q <= is_read;
      s2_q <= s2_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pipe_q <= '0;
    end else if (s1_q) begin
      pipe_q <= mem_rd_q;
    end
  end

  // Output enable and sleep gate the drivers without waiting for a clock
  wire out_valid = flow_through ? s1_q : s2_q; // RULE_10
  wire drive = out_valid & ~output_enable_n & awake; // RULE_06 RULE_18
  assign dq_out = (flow_through ? mem_rd_q : pipe_q) & par_mask;
  assign dq_oe = {DW{drive}} & par_mask; // RULE_13
  assign standby = sleep_request; // RULE_09

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_preset;
    begin_burst |=> (preset_q == $past(low_address_bits)) && (cnt_q == 2'h0);
  endproperty
  a_preset: assert property (p_preset) // RULE_01
    else $error("burst preset not taken from low address bits");

  property p_byte_lanes;
    (is_write && global_write_n && !byte_write_qualifier_n)
      |-> (lane_we == ~lane_write_selects_n);
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) // RULE_03
    else $error("byte write touched a lane not selected");

  property p_no_lane_without_write;
    (global_write_n && byte_write_qualifier_n) |-> (lane_we == '0);
  endproperty
  a_no_lane_without_write: assert property (p_no_lane_without_write) // RULE_02
    else $error("lane written with no write control asserted");

  property p_global;
    (is_write && !global_write_n) |-> (lane_we == '1);
  endproperty
  a_global: assert property (p_global) // RULE_04
    else $error("global write did not enable every lane");

  property p_select;
    (strobe_seen && !cs_active) |-> !begin_burst ##1 (state_q == ST_DESEL);
  endproperty
  a_select: assert property (p_select) // RULE_05
    else $error("access accepted without both chip selects");

  property p_oe;
    (output_enable_n || sleep_request) |-> (dq_oe == '0);
  endproperty
  a_oe: assert property (p_oe) // RULE_06
    else $error("drivers on while output enable high or asleep");

  property p_advance;
    (advance && !begin_burst) |=> (cnt_q == $past(cnt_q) + 2'h1);
  endproperty
  a_advance: assert property (p_advance) // RULE_07
    else $error("advance did not step the burst counter");

  property p_hold;
    (cont && counter_advance_n) |=> $stable(cnt_q) && $stable(preset_q);
  endproperty
  a_hold: assert property (p_hold) // RULE_07
    else $error("counter moved while advance was high");

  property p_linear;
    (advance && !linear_order_select_n)
      |-> (cur_low == 2'($past(cur_low) + 2'h1));
  endproperty
  a_linear: assert property (p_linear) // RULE_15
    else $error("linear burst address wrong");

  property p_interleave;
    (cont && linear_order_select_n) |-> (cur_low == (preset_q ^ cnt_d));
  endproperty
  a_interleave: assert property (p_interleave) // RULE_16
    else $error("interleaved burst address wrong");

  sequence s_four_steps;
    begin_burst ##1 (advance && !strobe_seen)[*4];
  endsequence
  property p_wrap;
    s_four_steps |-> (cur_low == $past(low_address_bits, 4));
  endproperty
  a_wrap: assert property (p_wrap) // RULE_17
    else $error("burst did not wrap to preset on fifth address");

  property p_sleep;
    sleep_request |-> !access ##1 (state_q == ST_DESEL);
  endproperty
  a_sleep: assert property (p_sleep) // RULE_09
    else $error("access accepted during sleep");

  property p_scd;
    (single_desel && s1_q && deselect_cmd && !flow_through) |=> !s2_q;
  endproperty
  a_scd: assert property (p_scd) // RULE_19
    else $error("single deselect left pipelined drivers on");

  property p_dcd;
    (!single_desel && s1_q && deselect_cmd && !flow_through
      && !is_write) |=> s2_q ##1 !s2_q;
  endproperty
  a_dcd: assert property (p_dcd) // RULE_19
    else $error("dual deselect did not hold output one cycle");

  property p_upper;
    cont |-> (cur_hi == hi_q) ##1 $stable(hi_q);
  endproperty
  a_upper: assert property (p_upper) // RULE_21
    else $error("upper address changed during burst");

  c_linear_burst: cover property (
    begin_burst && !linear_order_select_n ##1 advance[*3]);
  c_interleave_burst: cover property (
    begin_burst && linear_order_select_n ##1 advance[*3]);
  c_scd_deselect: cover property (
    s1_q && deselect_cmd && single_desel && !flow_through);
  c_global_write: cover property (is_write && !global_write_n);
endmodule : sbs_ctrl
`default_nettype wire

/* testbench/sbs_host.sv */
// Host controller model that drives the burst memory pins
`default_nettype none
module sbs_host
  import sbs_pkg::*;
(
  // Data pin, split the way the design splits it
  input wire logic [SBS_DATA_W-1:0] dq_out,
  input wire logic [SBS_DATA_W-1:0] dq_oe,
  output logic [SBS_DATA_W-1:0] dq_in,
  // Address and commands
  output logic [3:0] upper_address,
  output logic [1:0] low_address_bits,
  output logic processor_address_strobe_n,
  output logic controller_address_strobe_n,
  output logic chip_select_low_n,
  output logic chip_select_high,
  output logic counter_advance_n,
  output logic [3:0] lane_write_selects_n,
  output logic byte_write_qualifier_n,
  output logic global_write_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [SBS_DATA_W-1:0] drv_d = '0;
  logic drv_en = 1'b0;
  logic wr;
  // Released lines show inverted data, so a stale copy cannot pass
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & (drv_en ? drv_d : ~drv_d));

  // Kinds: 0 suspend, 1 start read, 2 start write, 3 advance read,
  // 4 advance write, 5 deselect with write, 6 processor start read
  task automatic cmd(input int k, input logic [5:0] a,
    input logic [SBS_DATA_W-1:0] d, input logic [4:0] bw);
    {upper_address, low_address_bits} = a;
    drv_d = d;
    wr = k == 2 || k == 4 || k == 5;
    drv_en = wr;
    controller_address_strobe_n = !(k == 1 || k == 2 || k == 5);
    processor_address_strobe_n = k != 6;
    chip_select_low_n = k == 5 && !a[0];
    chip_select_high = !(k == 5 && a[0]);
    counter_advance_n = !(k == 3 || k == 4);
    global_write_n = !(wr && bw[4]);
    byte_write_qualifier_n = !(wr && !bw[4]);
    lane_write_selects_n = bw[3:0];
  endtask : cmd

  initial begin
    cmd(0, 6'h00, '0, 5'h00);
  end
endmodule : sbs_host
`default_nettype wire

/* testbench/sbs_ctrl_tb.sv */
// Self-checking bench for the burst memory control block
`default_nettype none
module sbs_ctrl_tb
  import sbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, output_enable_n, sleep_request, standby;
  logic flow_through_select_n, linear_order_select_n;
  logic deselect_depth_select, parity_lane_enable_n;
  logic [3:0] upper_address, lane_write_selects_n;
  logic [1:0] low_address_bits;
  logic processor_address_strobe_n, controller_address_strobe_n;
  logic chip_select_low_n, chip_select_high, counter_advance_n;
  logic byte_write_qualifier_n, global_write_n;
  logic [35:0] dq_in, dq_out, dq_oe, m;
  logic [35:0] mdl [0:63];
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;

  sbs_ctrl #(.ADDR_W(6)) dut (
    .clk_sys, .rst, .upper_address, .low_address_bits,
    .processor_address_strobe_n, .controller_address_strobe_n,
    .chip_select_low_n, .chip_select_high, .counter_advance_n,
    .lane_write_selects_n, .byte_write_qualifier_n, .global_write_n,
    .output_enable_n, .sleep_request, .flow_through_select_n,
    .linear_order_select_n, .deselect_depth_select,
    .parity_lane_enable_n, .dq_in, .dq_out, .dq_oe, .standby
  );
  sbs_host h (
    .dq_out, .dq_oe, .dq_in, .upper_address, .low_address_bits,
    .processor_address_strobe_n, .controller_address_strobe_n,
    .chip_select_low_n, .chip_select_high, .counter_advance_n,
    .lane_write_selects_n, .byte_write_qualifier_n, .global_write_n
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      conclude();
    end
  end

  function automatic logic [5:0] seq(input logic [5:0] a,
    input logic [1:0] j);
    return {a[5:2], linear_order_select_n ? a[1:0] ^ j : a[1:0] + j};
  endfunction : seq

  // Two refused writes first, so a leftover read burst is shut off
  task automatic wr(input logic [5:0] a, input logic [35:0] d,
    input logic [4:0] bw);
    logic [35:0] dd;
    logic [5:0] x;
    for (int j = -2; j < 4; j++) begin
      @(negedge clk_sys);
      if (j < 0) begin
        h.cmd(5, 6'(j + 2), '0, 5'h1f);
      end else begin
        dd = d + 36'(j);
        x = seq(a, 2'(j));
        h.cmd(j ? 4 : 2, j ? a ^ 6'h3c : a, dd, bw);
        for (int i = 0; i < 4; i++) begin
          if (bw[4] || !bw[i]) mdl[x][9*i +: 9] = dd[9*i +: 9];
        end
      end
    end
  endtask : wr

  // Five addresses: the fourth advance must wrap to the preset
  task automatic rd(input logic [5:0] a, input int k, input int lat);
    logic [1:0] n;
    m = parity_lane_enable_n ? 36'h7fbfdfeff : 36'hfffffffff;
    for (int j = 0; j < lat + 6; j++) begin
      @(negedge clk_sys);
      // The sixth read is a suspend, so it stays on the wrapped preset
      if (j >= lat) begin
        n = j < lat + 5 ? 2'(j - lat) : 2'h0;
        chk(dq_out, mdl[seq(a, n)] & m);
        chk(dq_oe, m);
      end
      h.cmd(j == 0 ? k : (j < 5 ? 3 : 0), j ? a ^ 6'h3c : a, '0, '0);
    end
  endtask : rd

  task automatic t_linear();
    linear_order_select_n = 1'b0;
    wr(6'h01, 36'h912345678, 5'h1f);
    rd(6'h01, 1, 2);
    $display("test linear burst done");
  endtask : t_linear

  task automatic t_inter();
    linear_order_select_n = 1'b1;
    wr(6'h16, 36'h3cafe0001, 5'h1f);
    rd(6'h15, 6, 2);
    $display("test interleaved burst done");
  endtask : t_inter

  task automatic t_byte();
    linear_order_select_n = 1'b0;
    wr(6'h01, 36'h5a5a5a5a5, 5'h05);
    flow_through_select_n = 1'b0;
    rd(6'h02, 1, 1);
    flow_through_select_n = 1'b1;
    $display("test byte write done");
  endtask : t_byte

  task automatic t_sleep();
    parity_lane_enable_n = 1'b1;
    rd(6'h01, 1, 2);
    parity_lane_enable_n = 1'b0;
    sleep_request = 1'b1;
    #1 chk(36'(standby), 36'h1);
    chk(dq_oe, 36'h0);
    @(negedge clk_sys);
    h.cmd(2, 6'h01, '0, 5'h1f);
    @(negedge clk_sys);
    h.cmd(4, 6'h01, '0, 5'h1f);
    sleep_request = 1'b0;
    rd(6'h01, 1, 2);
    $display("test parity and sleep done");
  endtask : t_sleep

  task automatic t_desel(input logic dual);
    deselect_depth_select = !dual;
    rd(6'h02, 1, 2);
    output_enable_n = 1'b1;
    #1 chk(dq_oe, 36'h0);
    output_enable_n = 1'b0;
    #1 chk(dq_oe, m);
    @(negedge clk_sys);
    h.cmd(5, 6'h00, '0, 5'h1f);
    @(negedge clk_sys);
    chk(dq_oe, dual ? m : 36'h0);
    if (dual) chk(dq_out, mdl[6'h02]);
    @(negedge clk_sys);
    chk(dq_oe, 36'h0);
    deselect_depth_select = 1'b1;
    $display("test deselect depth done");
  endtask : t_desel

  initial begin
    rst = 1'b1;
    output_enable_n = 1'b0;
    sleep_request = SBS_DEF_SLEEP;
    flow_through_select_n = SBS_DEF_FLOW_N;
    linear_order_select_n = 1'b0;
    deselect_depth_select = SBS_DEF_DESEL_DEPTH;
    parity_lane_enable_n = SBS_DEF_PARITY_N;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_linear();
    t_inter();
    t_byte();
    t_sleep();
    t_desel(1'b0);
    t_desel(1'b1);
    conclude();
  end
endmodule : sbs_ctrl_tb
`default_nettype wire
